/* logic/crta_rtc.sv */
// Calendar clock with match alarm, reached over the processor I/O port.
// Assumes the crystal and line clock arrive as slow unsynchronised levels
// and that software follows the unlock, set, lock sequence.
module crta_rtc #(
  parameter int XTAL_DIV = crta_pkg::XTAL_HZ
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Count sources
  input  wire logic       xtalClkIn,
  input  wire logic       lineClkIn,
  // Processor I/O port
  input  wire logic [7:0] ioAddr,
  input  wire logic       ioWrEn,
  input  wire logic       ioRdEn,
  input  wire logic [7:0] ioWrData,
  output logic      [7:0] ioRdData,
  // Alarm request
  output logic            alarmIrq
);
  import crta_pkg::*;

  // ---------------------------------------------------------------
  // Behaviour summary
  // ---------------------------------------------------------------
  // Register layout, byte wide, one strobe per access:
  //   E0 seconds, E1 minutes, E2 hours, E3 weekday
  //   E4 day of month, E5 month, E6 year, E7 century
  //   E8 to EB alarm seconds, minutes, hours, weekday
  //   EC alarm enables, one bit per set-point
  //   ED control: unlock, line source, 50 Hz, irq enable, decimal
  //   ED bit 7 alarm flag, read only, cleared by the same read
  // Reads of unmapped offsets return zero; writes there are dropped.
  //
  // Count path:
  //   Both sources pass two flops before the edge detect
  //   Third flop only keeps the previous settled level
  //   Selected source edges feed the one-second divider
  //   Divider end gives a one-cycle tick enable
  //   Tick steps seconds; carries ripple upward in the same cycle
  //   Counts keep their value through reset, so time survives it
  //
  // Locking:
  //   Unlocked holds the divider at zero and stops counting
  //   Count writes land only while unlocked
  //   Any control write clears the divider, so the next second
  //   starts fresh; software writes seconds just before locking
  //
  // Alarm path:
  //   Compare request one cycle after a tick or a lock write
  //   The delay lets the compare see the freshly stepped counts
  //   Flag and request rise one cycle after the compare
  //   No enabled set-point means no alarm, by choice
  //   A hit in the cycle of a clearing read keeps the flag set,
  //   so an alarm is never lost to a racing read
  //
  // Limitations:
  //   Out-of-range written values simply count up until they wrap
  //   on the exact limit; software must write legal values
  //   Leap days follow the year only; century is not consulted
  //   Binary mode never inserts a leap day

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Binary value to packed decimal, values below 100 only
  function automatic logic [7:0] toBcd(input logic [7:0] b);
    toBcd = {4'(b / 8'd10), 4'(b % 8'd10)};
  endfunction

  // Last day of the month in binary; leap day only in decimal mode
  function automatic logic [7:0] lastDay(input logic [7:0] mon, input logic [7:0] yr,
                                         input logic bcd);
    logic leap;
    leap = 1'b0;
    if (bcd) begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    end
    case (bcd ? 8'((mon[7:4] * 4'd10) + mon[3:0]) : mon)
      8'd4, 8'd6, 8'd9, 8'd11: lastDay = DAYS_30;
      MON_FEB:                 lastDay = leap ? DAYS_29 : DAYS_28;
      default:                 lastDay = DAYS_31;
    endcase
  endfunction

  // Limit of each count, binary form
  function automatic logic [7:0] limitOf(input logic [2:0] idx, input logic [7:0] mon,
                                         input logic [7:0] yr, input logic bcd);
    case (idx)
      IDX_SEC, IDX_MIN: limitOf = LIM_SEC;
      IDX_HR:           limitOf = LIM_HR;
      IDX_DOW:          limitOf = LIM_DOW;
      IDX_DOM:          limitOf = lastDay(mon, yr, bcd);
      IDX_MON:          limitOf = LIM_MON;
      default:          limitOf = LIM_YR;
    endcase
  endfunction

  // Counts that restart at one rather than zero
  function automatic logic [7:0] firstOf(input logic [2:0] idx);
    if (idx == IDX_DOW || idx == IDX_DOM || idx == IDX_MON) begin
      firstOf = FIRST_ONE;
    end else begin
      firstOf = FIRST_ZERO;
    end
  endfunction

  // One step of a count: {carry, next value}
  function automatic logic [8:0] stepCount(input logic [7:0] v, input logic [7:0] limBin,
                                           input logic [7:0] first, input logic bcd);
    logic [7:0] lim;
    lim = bcd ? toBcd(limBin) : limBin;
    if (v == lim) begin
      stepCount = {1'b1, first};
    end else if (bcd && v[3:0] == DIGIT_MAX) begin
      stepCount = {1'b0, 4'(v[7:4] + 4'd1), 4'h0};
    end else begin
      stepCount = {1'b0, 8'(v + 8'd1)};
    end
  endfunction

  // ---------------------------------------------------------------
  // Source synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [2:0] xtalSync_reg;
  logic [2:0] lineSync_reg;

  // Third stage only remembers the previous settled level
  always_ff @(posedge core_clk) begin
    xtalSync_reg <= {xtalSync_reg[1:0], xtalClkIn};
    lineSync_reg <= {lineSync_reg[1:0], lineClkIn};
  end

  // ---------------------------------------------------------------
  // Control, divider and alarm state
  // ---------------------------------------------------------------
  logic       unlock_reg,   unlock_next;
  logic       lineSrc_reg,  lineSrc_next;
  logic       freq50_reg,   freq50_next;
  logic       irqEn_reg,    irqEn_next;
  logic       decimal_reg,  decimal_next;
  logic       alarmFlag_reg, alarmFlag_next;
  logic       alarmIrq_reg, alarmIrq_next;
  logic       cmpReq_reg,   cmpReq_next;
  logic [3:0] almEn_reg,    almEn_next;
  logic [15:0] divCnt_reg,  divCnt_next;
  logic [7:0] rdData_reg,   rdData_next;
  logic       tick;
  logic       srcEdge;
  logic       ctrlWr;
  logic       alarmHit;
  logic [15:0] divTarget;
  logic [7:0] cnt_reg  [NUM_COUNTS];
  logic [7:0] cnt_next [NUM_COUNTS];
  logic [7:0] alm_reg  [NUM_ALARMS];
  logic [7:0] alm_next [NUM_ALARMS];

  // Divider, control writes and alarm flag
  always_comb begin
    ctrlWr    = ioWrEn && ioAddr == ADDR_CTRL;
    srcEdge   = lineSrc_reg ? (lineSync_reg[1] && !lineSync_reg[2])
                            : (xtalSync_reg[1] && !xtalSync_reg[2]);
    divTarget = lineSrc_reg ? (freq50_reg ? LINE_50HZ : LINE_60HZ)
                            : 16'(XTAL_DIV);
    tick      = 1'b0;
    divCnt_next = divCnt_reg;
    if (ctrlWr || unlock_reg) begin
      divCnt_next = 16'h0000;
    end else if (srcEdge) begin
      if (divCnt_reg == 16'(divTarget - 16'd1)) begin
        divCnt_next = 16'h0000;
        tick        = 1'b1;
      end else begin
        divCnt_next = 16'(divCnt_reg + 16'd1);
      end
    end
    unlock_next  = unlock_reg;
    lineSrc_next = lineSrc_reg;
    freq50_next  = freq50_reg;
    irqEn_next   = irqEn_reg;
    decimal_next = decimal_reg;
    almEn_next   = almEn_reg;
    if (ctrlWr) begin
      unlock_next  = ioWrData[CTRL_UNLOCK];
      lineSrc_next = ioWrData[CTRL_LINE_SRC];
      freq50_next  = ioWrData[CTRL_FREQ_50];
      irqEn_next   = ioWrData[CTRL_IRQ_EN];
      decimal_next = ioWrData[CTRL_DECIMAL];
    end
    if (ioWrEn && ioAddr == ADDR_ALM_EN) begin
      almEn_next = ioWrData[3:0];
    end
    // Compare one cycle after the count moves, so new values are seen
    cmpReq_next = (tick && !unlock_reg) || (ctrlWr && !ioWrData[CTRL_UNLOCK]);
    alarmHit = cmpReq_reg && almEn_reg != 4'h0;
    for (int i = 0; i < NUM_ALARMS; i++) begin
      if (almEn_reg[i] && alm_reg[i] != cnt_reg[i]) begin
        alarmHit = 1'b0;
      end
    end
    // A new hit beats the read that clears
    alarmFlag_next = alarmHit || (alarmFlag_reg && !(ioRdEn && ioAddr == ADDR_CTRL));
    alarmIrq_next  = (alarmHit && irqEn_reg)
                   || (alarmIrq_reg && !(ioRdEn && ioAddr == ADDR_CTRL));
    rdData_next = rdData_reg;
    if (ioRdEn) begin
      rdData_next = 8'h00;
      if (ioAddr >= ADDR_SECOND && ioAddr < ADDR_ALM_SEC) begin
        rdData_next = cnt_reg[3'(ioAddr - ADDR_SECOND)];
      end else if (ioAddr >= ADDR_ALM_SEC && ioAddr < ADDR_ALM_EN) begin
        rdData_next = alm_reg[2'(ioAddr - ADDR_ALM_SEC)];
      end else if (ioAddr == ADDR_ALM_EN) begin
        rdData_next = {4'h0, almEn_reg};
      end else if (ioAddr == ADDR_CTRL) begin
        rdData_next = 8'h00;
        rdData_next[CTRL_UNLOCK]   = unlock_reg;
        rdData_next[CTRL_LINE_SRC] = lineSrc_reg;
        rdData_next[CTRL_FREQ_50]  = freq50_reg;
        rdData_next[CTRL_IRQ_EN]   = irqEn_reg;
        rdData_next[CTRL_DECIMAL]  = decimal_reg;
        rdData_next[CTRL_ALARM]    = alarmFlag_reg;
      end
    end
  end

  // Control registers; reset locks the clock and drops the alarm enables
  always_ff @(posedge core_clk) begin
    if (reset) begin
      unlock_reg    <= 1'b0;
      lineSrc_reg   <= 1'b0;
      freq50_reg    <= 1'b0;
      irqEn_reg     <= 1'b0;
      decimal_reg   <= 1'b0;
      alarmFlag_reg <= 1'b0;
      alarmIrq_reg  <= 1'b0;
      cmpReq_reg    <= 1'b0;
      almEn_reg     <= 4'h0;
      divCnt_reg    <= 16'h0000;
      rdData_reg    <= 8'h00;
    end else begin
      unlock_reg    <= unlock_next;
      lineSrc_reg   <= lineSrc_next;
      freq50_reg    <= freq50_next;
      irqEn_reg     <= irqEn_next;
      decimal_reg   <= decimal_next;
      alarmFlag_reg <= alarmFlag_next;
      alarmIrq_reg  <= alarmIrq_next;
      cmpReq_reg    <= cmpReq_next;
      almEn_reg     <= almEn_next;
      divCnt_reg    <= divCnt_next;
      rdData_reg    <= rdData_next;
    end
  end

  // ---------------------------------------------------------------
  // Time counts and alarm set-points
  // ---------------------------------------------------------------
  // Carry ripples from seconds upward in one cycle
  always_comb begin
    logic       carry;
    logic [8:0] stepped;
    carry   = tick && !unlock_reg;
    stepped = 9'h000;
    for (int i = 0; i < NUM_COUNTS; i++) begin
      cnt_next[i] = cnt_reg[i];
      if (carry) begin
        stepped = stepCount(cnt_reg[i],
                            limitOf(3'(i), cnt_reg[IDX_MON], cnt_reg[IDX_YR], decimal_reg),
                            firstOf(3'(i)), decimal_reg);
        cnt_next[i] = stepped[7:0];
        // Weekday rolls on its own; the day count takes the hour carry
        carry = (i == IDX_DOW) ? carry : stepped[8];
      end
      if (unlock_reg && ioWrEn && ioAddr == 8'(ADDR_SECOND + 8'(i))) begin
        cnt_next[i] = ioWrData;
      end
    end
    for (int j = 0; j < NUM_ALARMS; j++) begin
      alm_next[j] = alm_reg[j];
      if (ioWrEn && ioAddr == 8'(ADDR_ALM_SEC + 8'(j))) begin
        alm_next[j] = ioWrData;
      end
    end
  end

  // Counts and set-points keep their values through reset
  always_ff @(posedge core_clk) begin
    cnt_reg <= cnt_next;
    alm_reg <= alm_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign ioRdData = rdData_reg;
  assign alarmIrq = alarmIrq_reg;

endmodule

/* common/crta_pkg.sv */
// Constants shared by the calendar clock with alarm: register offsets,
// control field positions, count limits and divider figures.
// Assumes an 8-bit processor I/O port with byte-wide registers.
//
// Operation
// - Separate counts, seconds through century, 24-hour
// - Format bit picks binary or packed decimal
// - Day-of-month correct; leap years only decimal
// - Alarm matches every enabled set-point together
// - Alarm sets flag; interrupt when enabled
// - Reading control register clears flag and interrupt
// - Alarm registers writable locked or unlocked
// - Alarm compared each one-second count advance
// - Writing unlock zero forces immediate comparison
// - Crystal or line clock source, selectable
// - Control register write resets the divider
// - Alarm enables cleared after power-up
// - Clearing unlock resets then runs divider
// - Unlocked stops counting, allows count writes
// - Reset leaves clock locked
// - Reset leaves count registers untouched
// - Seconds: decimal tens 0-5, binary 00h-3Bh
// - Minutes: binary 00h-3Bh, decimal ones 0-9
// - Hours: binary 00h-17h, decimal tens 0-2
// - Weekday, day and month start at 01h
package crta_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SECOND  = 8'he0;
  localparam logic [7:0] ADDR_MINUTE  = 8'he1;
  localparam logic [7:0] ADDR_ALM_SEC = 8'he8;
  localparam logic [7:0] ADDR_ALM_EN  = 8'hec;
  localparam logic [7:0] ADDR_CTRL    = 8'hed;
  localparam int         NUM_COUNTS   = 8;
  localparam int         NUM_ALARMS   = 4;

  // Count indices, offset from the seconds register
  localparam logic [2:0] IDX_SEC = 3'h0;
  localparam logic [2:0] IDX_MIN = 3'h1;
  localparam logic [2:0] IDX_HR  = 3'h2;
  localparam logic [2:0] IDX_DOW = 3'h3;
  localparam logic [2:0] IDX_DOM = 3'h4;
  localparam logic [2:0] IDX_MON = 3'h5;
  localparam logic [2:0] IDX_YR  = 3'h6;
  localparam logic [2:0] IDX_CEN = 3'h7;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_UNLOCK   = 0;
  localparam int CTRL_LINE_SRC = 1;
  localparam int CTRL_FREQ_50  = 2;
  localparam int CTRL_IRQ_EN   = 3;
  localparam int CTRL_DECIMAL  = 4;
  localparam int CTRL_ALARM    = 7;

  // ---------------------------------------------------------------
  // Count limits, binary form
  // ---------------------------------------------------------------
  localparam logic [7:0] LIM_SEC  = 8'h3b;
  localparam logic [7:0] LIM_HR   = 8'h17;
  localparam logic [7:0] LIM_DOW  = 8'h07;
  localparam logic [7:0] LIM_MON  = 8'h0c;
  localparam logic [7:0] LIM_YR   = 8'h63;
  localparam logic [7:0] DAYS_31  = 8'h1f;
  localparam logic [7:0] DAYS_30  = 8'h1e;
  localparam logic [7:0] DAYS_29  = 8'h1d;
  localparam logic [7:0] DAYS_28  = 8'h1c;
  localparam logic [7:0] MON_FEB  = 8'h02;
  localparam logic [7:0] FIRST_ONE  = 8'h01;
  localparam logic [7:0] FIRST_ZERO = 8'h00;
  localparam logic [3:0] DIGIT_MAX  = 4'h9;

  // ---------------------------------------------------------------
  // Divider figures
  // ---------------------------------------------------------------
  localparam int         XTAL_HZ   = 32768;
  localparam logic [15:0] LINE_50HZ = 16'h0032;
  localparam logic [15:0] LINE_60HZ = 16'h003c;

endpackage

/* test/crta_rtc_assertions.sv */
// Port checker for the calendar clock: register reads and alarm request.
// Assumes it is bound to every crta_rtc instance.
module crta_rtc_chk #(
  parameter int XTAL_DIV = 32768
) (
  // Clock, reset and I/O port
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [7:0] ioAddr,
  input wire logic       ioWrEn,
  input wire logic       ioRdEn,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic       alarmIrq
);
  import crta_pkg::*;
  logic irqEn_reg;
  logic irqEn_next;
  logic ctlRd;
  logic ctlWr;
  assign ctlRd = ioRdEn && ioAddr == ADDR_CTRL;
  assign ctlWr = ioWrEn && ioAddr == ADDR_CTRL;
  // Mirror of the interrupt enable; reads never change it
  always_comb begin
    irqEn_next = ctlWr ? ioWrData[CTRL_IRQ_EN] : irqEn_reg;
  end
  always_ff @(posedge core_clk) begin
    irqEn_reg <= reset ? 1'b0 : irqEn_next;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  reset_clear_a: assert property (disable iff (1'b0) reset |=> ioRdData == 8'h00 && !alarmIrq)
    else $error("reset left read data or alarm set");
  unmapped_zero_a: assert property ((ioRdEn && (ioAddr > ADDR_CTRL || ioAddr < ADDR_SECOND))
    |=> ioRdData == 8'h00) else $error("unmapped read not zero");
  rd_hold_a: assert property (!ioRdEn |=> $stable(ioRdData))
    else $error("read data moved without a read");
  irq_fall_a: assert property ($fell(alarmIrq) |-> $past(ctlRd) || $past(reset))
    else $error("alarm request dropped without control read");
  flag_seen_a: assert property (ctlRd && alarmIrq |=> ioRdData[CTRL_ALARM])
    else $error("alarm flag clear while request raised");
  ctrl_resv_a: assert property (ctlRd |=> ioRdData[6:5] == 2'b00)
    else $error("reserved control bits read nonzero");
  irq_enable_a: assert property ($rose(alarmIrq) |-> irqEn_reg || $past(irqEn_reg))
    else $error("alarm request raised while disabled");
  ctrl_back_a: assert property (ctlWr ##1 !ioWrEn ##1 ctlRd
    |=> ioRdData[4:0] == $past(ioWrData[4:0], 3))
    else $error("control readback differs");
endmodule

bind crta_rtc crta_rtc_chk #(.XTAL_DIV(XTAL_DIV)) u_chk (.core_clk(core_clk), .reset(reset),
  .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioWrData(ioWrData),
  .ioRdData(ioRdData), .alarmIrq(alarmIrq));

/* test/crta_src_model.sv */
// Count source model: crystal level and mains-derived line level.
// Assumes both run free; periods are scaled far down for simulation.
module crta_src_model #(
  parameter int XTAL_HALF = 103,
  parameter int LINE_HALF = 97
) (
  // Source levels
  output logic xtalClk,
  output logic lineClk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Odd half periods keep both unrelated in phase to the core clock
  initial begin
    xtalClk = 1'b0;
    forever #(XTAL_HALF) xtalClk = ~xtalClk;
  end
  initial begin
    lineClk = 1'b0;
    forever #(LINE_HALF) lineClk = ~lineClk;
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the calendar clock with alarm.
// Assumes the source model periods: 20.6 and 19.4 core cycles.
module tb_top;
  import crta_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 4;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic       ioWrEn = 1'b0;
  logic       ioRdEn = 1'b0;
  logic [7:0] ioAddr = 8'h00;
  logic [7:0] ioWrData = 8'h00;
  logic [7:0] ioRdData;
  logic [7:0] rdv;
  logic       xtalClkIn;
  logic       lineClkIn;
  logic       alarmIrq;
  int         miscompares = 0;
  int         checked = 0;
  int         cycles = 0;

  crta_rtc #(.XTAL_DIV(DIV)) u_dut (.core_clk(core_clk), .reset(reset),
    .xtalClkIn(xtalClkIn), .lineClkIn(lineClkIn), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
    .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData(ioRdData), .alarmIrq(alarmIrq));
  crta_src_model u_src (.xtalClk(xtalClkIn), .lineClk(lineClkIn));

  // Clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Accesses end with an idle cycle so strobes never toggle twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = 1'b1;
    @(posedge core_clk) #1 ioWrEn = 1'b0;
    @(posedge core_clk) #1;
  endtask

  task automatic rd(input logic [7:0] a);
    ioAddr = a;
    ioRdEn = 1'b1;
    @(posedge core_clk) #1 ioRdEn = 1'b0;
    rdv = ioRdData;
    @(posedge core_clk) #1;
  endtask

  // Polls seconds until it moves; returns elapsed cycles
  task automatic wait_tick(output int n);
    logic [7:0] s;
    rd(ADDR_SECOND);
    s = rdv;
    n = cycles;
    do rd(ADDR_SECOND); while (rdv === s);
    n = cycles - n;
  endtask

  task automatic s_lock();
    int n;
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_SECOND, 8'h2a);
    @(posedge core_clk) #1 reset = 1'b1;
    @(posedge core_clk) #1 reset = 1'b0;
    rd(ADDR_SECOND); chk(rdv, 8'h2a);
    rd(ADDR_CTRL); chk(rdv, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_SECOND, 8'h3b);
    wr(ADDR_MINUTE, 8'h05);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL); chk(rdv, 8'h00);
    wr(ADDR_SECOND, 8'h11);
    rd(ADDR_SECOND); chk(rdv, 8'h3b);
    wait_tick(n);
    rd(ADDR_SECOND); chk(rdv, 8'h00);
    rd(ADDR_MINUTE); chk(rdv, 8'h06);
    rd(8'hf0); chk(rdv, 8'h00);
  endtask

  // Tick spacing per source: crystal, line 60 Hz, line 50 Hz
  task automatic s_rate();
    logic [7:0] ctl[3] = '{8'h00, 8'h02, 8'h06};
    int exp[3] = '{82, 1164, 970};
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, ctl[i]);
      wait_tick(n);
      wait_tick(n);
      chk(8'((n > exp[i] - 8) && (n < exp[i] + 8)), 8'h01);
    end
  endtask

  task automatic s_alarm();
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_SECOND, 8'h10);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_ALM_SEC, 8'h12);
    wr(ADDR_ALM_EN, 8'h01);
    while (alarmIrq !== 1'b1) @(posedge core_clk);
    #1 rd(ADDR_SECOND); chk(rdv, 8'h12);
    rd(ADDR_CTRL); chk(rdv & 8'h8f, 8'h88);
    chk({7'h00, alarmIrq}, 8'h00);
    rd(ADDR_CTRL); chk(rdv & 8'h80, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_SECOND, 8'h20);
    wr(ADDR_MINUTE, 8'h00);
    wr(ADDR_ALM_SEC, 8'h20);
    wr(ADDR_ALM_SEC + 8'h01, 8'h33);
    wr(ADDR_ALM_EN, 8'h03);
    wr(ADDR_CTRL, 8'h08);
    @(posedge core_clk) #1 chk({7'h00, alarmIrq}, 8'h00);
    wr(ADDR_ALM_SEC + 8'h01, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    @(posedge core_clk) #1 chk({7'h00, alarmIrq}, 8'h01);
    rd(ADDR_CTRL);
  endtask

  task automatic s_bcd();
    int n;
    wr(ADDR_CTRL, 8'h11);
    wr(ADDR_SECOND, 8'h59);
    wr(ADDR_MINUTE, 8'h09);
    wr(ADDR_CTRL, 8'h10);
    wait_tick(n);
    rd(ADDR_SECOND); chk(rdv, 8'h00);
    rd(ADDR_MINUTE); chk(rdv, 8'h10);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    rd(ADDR_ALM_EN); chk(rdv & 8'h0f, 8'h00);
    s_lock();
    s_rate();
    s_alarm();
    s_bcd();
    complete_run();
  end
endmodule
